// ==== rtl/bcrc_fifo.sv ====
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: Synchronous active-high reset; DEPTH is a power of two.
// Notes: Full and empty come from a count, so in_ready is honest.
`timescale 1ns/1ps
module bcrc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } bcrc_fifo_st_t;

    bcrc_fifo_st_t st_r;
    bcrc_fifo_st_t st_nxt;
    logic          push;
    logic          pop;

    assign in_ready_o  = (st_r.cnt != DEPTH[PW:0]);
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = st_r.mem[st_r.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_i;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : bcrc_fifo

// ==== rtl/bcrc_unit.sv ====
// Purpose: Byte serial CRC16 unit with an AXI4-Lite register slave.
// Assumes: One clock, synchronous active-high reset, one access of each kind at a time.
// Notes: Input bytes pass through a FIFO; a write response waits for FIFO room.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module bcrc_unit #(
    parameter int FIFO_DEPTH = bcrc_pkg::BCRC_FIFO_DEPTH
) (
    input  wire logic                         sys_clk_i,
    input  wire logic                         srst_i,
    input  wire logic [bcrc_pkg::BCRC_AW-1:0] s_axi_awaddr_i,
    input  wire logic [2:0]                   s_axi_awprot_i,
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [bcrc_pkg::BCRC_DW-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    output logic [1:0]                        s_axi_bresp_o,
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    input  wire logic [bcrc_pkg::BCRC_AW-1:0] s_axi_araddr_i,
    input  wire logic [2:0]                   s_axi_arprot_i,
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    output logic [bcrc_pkg::BCRC_DW-1:0]      s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i
);
    import bcrc_pkg::*;

    typedef struct packed {
        bcrc_wr_state_t      wst;
        logic                aw_got;
        logic                w_got;
        logic [BCRC_AW-1:0]  awaddr;
        logic [BCRC_DW-1:0]  wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [BCRC_DW-1:0]  rdata;
        logic [1:0]          rresp;
        logic [7:0]          byte_in;
        logic [15:0]         sum;
        logic                sel;
    } bcrc_st_t;

    bcrc_st_t   st_r;
    bcrc_st_t   st_nxt;
    bcrc_item_t push_item;
    logic       push_valid;
    logic       push_ready;
    bcrc_item_t pop_item;
    logic       pop_valid;
    logic       pop_ready;

    // One full byte update: fold the byte into the top half, then eight bit steps.
    function automatic logic [15:0] bcrc_byte_update(input logic [15:0] sum,
                                                     input logic [7:0]  din,
                                                     input logic        sel);
        logic [15:0] t;
        logic [15:0] fb;
        logic        top;
        t  = sum ^ {din, 8'h00};
        fb = sel ? BCRC_FB_CRC16 : BCRC_FB_CCITT;
        for (int i = 0; i < BCRC_STEPS; i++) begin
            top = t[15];
            t   = {t[14:0], 1'b0};
            if (top) begin
                t = t ^ fb;
            end
        end
        return t;
    endfunction : bcrc_byte_update

    function automatic logic [7:0] bcrc_merge(input logic [7:0] old,
                                              input logic [7:0] nw,
                                              input logic       en);
        return en ? nw : old;
    endfunction : bcrc_merge

    // Each accepted byte carries the polynomial selection in force at its write.
    bcrc_fifo #(
        .WIDTH ($bits(bcrc_item_t)),
        .DEPTH (FIFO_DEPTH)
    ) i_bcrc_fifo (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .in_data_i   (push_item),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .out_data_o  (pop_item),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready)
    );

    logic wr_fire;
    logic wr_input;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_mapped;
    logic wr_stall;
    logic sum_write;

    always_comb begin
        wr_input  = 1'b0;
        wr_low    = 1'b0;
        wr_high   = 1'b0;
        wr_ctrl   = 1'b0;
        if (st_r.awaddr == BCRC_OFS_INPUT) begin
            wr_input = 1'b1;
        end else if (st_r.awaddr == BCRC_OFS_LOW) begin
            wr_low = 1'b1;
        end else if (st_r.awaddr == BCRC_OFS_HIGH) begin
            wr_high = 1'b1;
        end else if (st_r.awaddr == BCRC_OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end
        wr_mapped = wr_input | wr_low | wr_high | wr_ctrl;
        // A byte write to the input waits for FIFO room; sum writes wait for a drain.
        wr_stall  = (wr_input && st_r.wstrb[0] && !push_ready)
                  || ((wr_low || wr_high) && pop_valid);
        wr_fire   = (st_r.wst == BCRC_WR_IDLE) && st_r.aw_got && st_r.w_got && !wr_stall;
        sum_write = wr_fire && (wr_low || wr_high);
    end

    assign push_valid     = wr_fire && wr_input && st_r.wstrb[0];
    assign push_item.data = st_r.wdata[7:0];
    assign push_item.sel  = st_r.sel;
    assign pop_ready      = !sum_write;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.awready = 1'b0;
        st_nxt.wready  = 1'b0;
        st_nxt.arready = 1'b0;

        // Write address and data are taken independently, in either order.
        if (!st_r.aw_got && st_r.wst == BCRC_WR_IDLE && s_axi_awvalid_i && !st_r.awready) begin
            st_nxt.awready = 1'b1;
            st_nxt.aw_got  = 1'b1;
            st_nxt.awaddr  = {s_axi_awaddr_i[BCRC_AW-1:2], 2'b00};
        end
        if (!st_r.w_got && st_r.wst == BCRC_WR_IDLE && s_axi_wvalid_i && !st_r.wready) begin
            st_nxt.wready = 1'b1;
            st_nxt.w_got  = 1'b1;
            st_nxt.wdata  = s_axi_wdata_i;
            st_nxt.wstrb  = s_axi_wstrb_i;
        end

        // The running checksum takes the next queued byte in one cycle.
        if (pop_valid && pop_ready) begin
            st_nxt.sum = bcrc_byte_update(st_r.sum, pop_item.data, pop_item.sel);
        end

        case (st_r.wst)
            BCRC_WR_IDLE: begin
                if (wr_fire) begin
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got  = 1'b0;
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bresp  = wr_mapped ? BCRC_RESP_OKAY : BCRC_RESP_SLVERR;
                    st_nxt.wst    = BCRC_WR_RESP;
                    if (wr_input) begin
                        st_nxt.byte_in = bcrc_merge(st_r.byte_in, st_r.wdata[7:0],
                                                    st_r.wstrb[0]);
                    end
                    if (wr_low) begin
                        st_nxt.sum[7:0] = bcrc_merge(st_r.sum[7:0], st_r.wdata[7:0],
                                                     st_r.wstrb[0]);
                    end
                    if (wr_high) begin
                        st_nxt.sum[15:8] = bcrc_merge(st_r.sum[15:8], st_r.wdata[7:0],
                                                      st_r.wstrb[0]);
                    end
                    if (wr_ctrl && st_r.wstrb[0]) begin
                        st_nxt.sel = st_r.wdata[BCRC_SEL_BIT];
                    end
                end
            end
            BCRC_WR_RESP: begin
                if (s_axi_bready_i) begin
                    st_nxt.bvalid = 1'b0;
                    st_nxt.wst    = BCRC_WR_IDLE;
                end
            end
            default: begin
                st_nxt.wst = BCRC_WR_IDLE;
            end
        endcase

        // Reads are answered in the same cycle the address is taken: rvalid rises together with arready.
        if (st_r.rvalid) begin
            if (s_axi_rready_i) begin
                st_nxt.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid_i && !st_r.arready) begin
            st_nxt.arready = 1'b1;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = BCRC_RESP_OKAY;
            st_nxt.rdata   = '0;
            if ({s_axi_araddr_i[BCRC_AW-1:2], 2'b00} == BCRC_OFS_INPUT) begin
                st_nxt.rdata[7:0] = st_r.byte_in;
            end else if ({s_axi_araddr_i[BCRC_AW-1:2], 2'b00} == BCRC_OFS_LOW) begin
                st_nxt.rdata[7:0] = st_r.sum[7:0];
            end else if ({s_axi_araddr_i[BCRC_AW-1:2], 2'b00} == BCRC_OFS_HIGH) begin
                st_nxt.rdata[7:0] = st_r.sum[15:8];
            end else if ({s_axi_araddr_i[BCRC_AW-1:2], 2'b00} == BCRC_OFS_CTRL) begin
                st_nxt.rdata[BCRC_SEL_BIT] = st_r.sel;
            end else begin
                st_nxt.rresp = BCRC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r         <= '0;
            st_r.wst     <= BCRC_WR_IDLE;
            st_r.byte_in <= BCRC_BYTE_RST;
            st_r.sum     <= {BCRC_BYTE_RST, BCRC_BYTE_RST};
            st_r.sel     <= BCRC_SEL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready_o = st_r.awready;
    assign s_axi_wready_o  = st_r.wready;
    assign s_axi_bresp_o   = st_r.bresp;
    assign s_axi_bvalid_o  = st_r.bvalid;
    assign s_axi_arready_o = st_r.arready;
    assign s_axi_rdata_o   = st_r.rdata;
    assign s_axi_rresp_o   = st_r.rresp;
    assign s_axi_rvalid_o  = st_r.rvalid;

    // Bit-serial form of the checksum, kept apart from the byte-wise logic above so
    // that the check AST_SUM_UPDATE below compares two different formulations of one polynomial.
    function automatic logic [15:0] bcrc_serial_ref(input logic [15:0] sum,
                                                    input logic [7:0]  din,
                                                    input logic        sel);
        logic [15:0] r;
        logic [15:0] fb;
        logic        fbit;
        r  = sum;
        fb = sel ? BCRC_FB_CRC16 : BCRC_FB_CCITT;
        for (int i = BCRC_STEPS - 1; i >= 0; i--) begin
            fbit = r[15] ^ din[i];
            r    = {r[14:0], 1'b0};
            if (fbit) begin
                r = r ^ fb;
            end
        end
        return r;
    endfunction : bcrc_serial_ref

    logic [15:0] chk_expect;
    assign chk_expect = bcrc_serial_ref(st_r.sum, pop_item.data, pop_item.sel);

    AST_SUM_UPDATE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (pop_valid && pop_ready) |=> (st_r.sum == $past(chk_expect)))
        else $error("Checksum did not take the byte update.");

    // A byte queued into an empty FIFO is folded in at the next edge, leaving it empty.
    sequence seq_byte_queued;
        push_valid && !pop_valid;
    endsequence

    sequence seq_byte_folded;
        (pop_valid && pop_ready) ##1 !pop_valid;
    endsequence

    AST_ONE_CYCLE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        seq_byte_queued |=> seq_byte_folded)
        else $error("Byte was not applied in time.");

    AST_CCITT_ONE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (pop_valid && pop_ready && !pop_item.sel && st_r.sum == 16'h0000
         && pop_item.data == 8'h01) |=> (st_r.sum == BCRC_FB_CCITT))
        else $error("CCITT feedback constant wrong.");

    AST_CRC16_ONE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (pop_valid && pop_ready && pop_item.sel && st_r.sum == 16'h0000
         && pop_item.data == 8'h01) |=> (st_r.sum == BCRC_FB_CRC16))
        else $error("CRC-16 feedback constant wrong.");

    AST_CTRL_ZERO: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (st_r.rvalid && $rose(st_r.rvalid) && $past(s_axi_araddr_i) == BCRC_OFS_CTRL)
        |-> (st_r.rdata[BCRC_DW-1:1] == '0))
        else $error("Control upper bits not zero.");

    AST_SEL_HOLD: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (wr_fire && wr_ctrl && !(pop_valid && pop_ready)) |=> (st_r.sum == $past(st_r.sum)))
        else $error("Polynomial change disturbed checksum.");

    AST_SUM_WRITE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (sum_write && wr_high && st_r.wstrb[0]) |=> (st_r.sum[15:8] == $past(st_r.wdata[7:0])))
        else $error("Checksum high byte not written.");

    AST_IDLE_SUM: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (!pop_valid && !sum_write) |=> $stable(st_r.sum))
        else $error("Checksum moved without a byte.");

    AST_WR_RESP: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_fire |=> s_axi_bvalid_o)
        else $error("Write response missing.");

    // Register stores, queue draining and bus handshakes.
    AST_IN_WRITE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (wr_fire && wr_input && st_r.wstrb[0]) |=> (st_r.byte_in == $past(st_r.wdata[7:0])))
        else $error("Input byte register not written.");

    AST_LOW_WRITE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (sum_write && wr_low && st_r.wstrb[0]) |=> (st_r.sum[7:0] == $past(st_r.wdata[7:0])))
        else $error("Checksum low byte not written.");

    AST_SEL_WRITE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (wr_fire && wr_ctrl && st_r.wstrb[0])
        |=> (st_r.sel == $past(st_r.wdata[BCRC_SEL_BIT])))
        else $error("Generator select not written.");

    AST_QUEUE_NO_WAIT: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        pop_valid |-> pop_ready)
        else $error("Queued byte was held back.");

    AST_AW_PULSE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_axi_awready_o |=> !s_axi_awready_o)
        else $error("Write address ready longer than one cycle.");

    AST_W_PULSE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_axi_wready_o |=> !s_axi_wready_o)
        else $error("Write data ready longer than one cycle.");

    AST_AR_ANSWER: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_axi_arready_o |-> s_axi_rvalid_o)
        else $error("Read address taken without read data.");

    AST_AR_PULSE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_axi_arready_o |=> !s_axi_arready_o)
        else $error("Read address ready longer than one cycle.");
endmodule : bcrc_unit

// ==== shared/bcrc_pkg.sv ====
// Purpose: Constants and carrier types for the byte serial CRC16 unit.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Registers hold eight bits in the low lane; upper bits read as zero.
// Notes on behaviour
// - Byte-wide read/write input register, reset zero; each write feeds one byte.
// - Each input write combines the held checksum and the byte, replacing the pair.
// - Whole eight-bit update finishes in one cycle; next access sees it.
// - Control bit 0 picks polynomial: 0 CCITT, 1 CRC-16; resets to 0.
// - CCITT selection uses feedback constant 1021h on a step whose top bit is one.
// - CRC-16 selection uses feedback constant 8005h on a step whose top bit is one.
// - Each update starts by XORing the byte into the checksum's upper eight bits.
// - Each bit step shifts the temporary value left one, zero into bit 0.
// - After the shift, XOR in feedback only when the bit shifted out was one.
// - Shift and conditional feedback repeat eight times per input byte.
// - Final result stored with upper byte high register, lower byte low register.
// - Checksum low and high registers are eight bits, read/write, reset zero.
// - Control bits 7 to 1 ignore writes and read as zero.
// - Only the two fixed polynomials exist; no programmable generator.
package bcrc_pkg;
    localparam int          BCRC_AW         = 4;
    localparam int          BCRC_DW         = 32;
    localparam logic [3:0]  BCRC_OFS_INPUT  = 4'h0;
    localparam logic [3:0]  BCRC_OFS_LOW    = 4'h4;
    localparam logic [3:0]  BCRC_OFS_HIGH   = 4'h8;
    localparam logic [3:0]  BCRC_OFS_CTRL   = 4'hc;
    localparam logic [7:0]  BCRC_BYTE_RST   = 8'h00;
    localparam logic        BCRC_SEL_RST    = 1'b0;
    localparam int          BCRC_SEL_BIT    = 0;
    localparam logic [15:0] BCRC_FB_CCITT   = 16'h1021;
    localparam logic [15:0] BCRC_FB_CRC16   = 16'h8005;
    localparam int          BCRC_STEPS      = 8;
    localparam logic [1:0]  BCRC_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  BCRC_RESP_SLVERR = 2'b10;
    localparam int          BCRC_FIFO_DEPTH = 4;

    typedef struct packed {
        logic [7:0] data;
        logic       sel;
    } bcrc_item_t;

    typedef enum logic [0:0] {
        BCRC_WR_IDLE,
        BCRC_WR_RESP
    } bcrc_wr_state_t;
endpackage : bcrc_pkg

// ==== test/bcrc_unit_tb_top.sv ====
// Purpose: Self-checking bench for the byte serial CRC16 unit over AXI4-Lite.
// Assumes: Bench is the bus master; protection bits unused, all strobes set.
// Notes: Expected sums come from fixed tables or a bench-side bitwise model.
`timescale 1ns/1ps
module bcrc_unit_tb_top;
    import bcrc_pkg::*;
    logic        sys_clk    = 1'b0;
    logic        srst       = 1'b1;
    logic [3:0]  awaddr     = 4'h0;
    logic        awvalid    = 1'b0;
    logic [31:0] wdata      = 32'h0;
    logic        wvalid     = 1'b0;
    logic        bready     = 1'b0;
    logic [3:0]  araddr     = 4'h0;
    logic        arvalid    = 1'b0;
    logic        rready     = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          errors     = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    logic [15:0] tab_cc [8] = '{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                16'h4084, 16'h50a5, 16'h60c6, 16'h70e7};
    logic [15:0] tab_16 [8] = '{16'h0000, 16'h8005, 16'h800f, 16'h000a,
                                16'h801b, 16'h001e, 16'h0014, 16'h8011};
    logic [7:0]  seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    logic [15:0] seq_cc [4] = '{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa};
    logic [15:0] seq_16 [4] = '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43};

    bcrc_unit i_bcrc_unit (
        .sys_clk_i(sys_clk), .srst_i(srst),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready)
    );

    always #2.5 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // The whole run needs some hundreds of cycles; this ceiling only catches a hang.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, BCRC_RESP_OKAY}, "write response");
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, BCRC_RESP_OKAY}, "read response");
    endtask : axi_rd

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [31:0] v;
        axi_rd(a, v);
        check(v, {24'h0, exp}, what);
    endtask : chk_reg

    task automatic chk_sum(input logic [15:0] exp, input string what);
        chk_reg(BCRC_OFS_LOW, exp[7:0], what);
        chk_reg(BCRC_OFS_HIGH, exp[15:8], what);
    endtask : chk_sum

    // The checksum settles one cycle after the byte enters the queue.
    task automatic feed(input logic [7:0] d);
        axi_wr(BCRC_OFS_INPUT, d);
        repeat (2) @(posedge sys_clk);
    endtask : feed

    task automatic clr();
        axi_wr(BCRC_OFS_LOW, 8'h00);
        axi_wr(BCRC_OFS_HIGH, 8'h00);
    endtask : clr

    function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d,
                                            input logic sel);
        logic [15:0] t;
        t = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            t = t[15] ? ({t[14:0], 1'b0} ^ (sel ? 16'h8005 : 16'h1021)) : {t[14:0], 1'b0};
        end
        return t;
    endfunction : crc_ref

    task automatic t_reset();
        chk_reg(BCRC_OFS_INPUT, 8'h00, "input reset");
        chk_reg(BCRC_OFS_LOW, 8'h00, "low reset");
        chk_reg(BCRC_OFS_HIGH, 8'h00, "high reset");
        chk_reg(BCRC_OFS_CTRL, 8'h00, "control reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_ctrl();
        axi_wr(BCRC_OFS_CTRL, 8'hfe);
        chk_reg(BCRC_OFS_CTRL, 8'h00, "control upper bits");
        axi_wr(BCRC_OFS_CTRL, 8'hff);
        chk_reg(BCRC_OFS_CTRL, 8'h01, "control select");
        $display("test control done");
    endtask : t_ctrl

    task automatic t_single();
        for (int s = 0; s < 2; s++) begin
            axi_wr(BCRC_OFS_CTRL, 8'(s));
            for (int d = 0; d < 8; d++) begin
                clr();
                feed(8'(d));
                chk_sum(s ? tab_16[d] : tab_cc[d], "single byte");
            end
        end
        $display("test single byte done");
    endtask : t_single

    task automatic t_seq();
        for (int s = 0; s < 2; s++) begin
            axi_wr(BCRC_OFS_CTRL, 8'(s));
            clr();
            for (int i = 0; i < 4; i++) begin
                feed(seq_in[i]);
                chk_sum(s ? seq_16[i] : seq_cc[i], "stepwise run");
            end
            clr();
            for (int i = 0; i < 4; i++) axi_wr(BCRC_OFS_INPUT, seq_in[i]);
            repeat (6) @(posedge sys_clk);
            chk_sum(s ? seq_16[3] : seq_cc[3], "back to back run");
            chk_reg(BCRC_OFS_INPUT, 8'h12, "input readback");
        end
        $display("test sequence done");
    endtask : t_seq

    task automatic t_preset();
        logic [15:0] exp;
        axi_wr(BCRC_OFS_CTRL, 8'h00);
        axi_wr(BCRC_OFS_LOW, 8'h34);
        axi_wr(BCRC_OFS_HIGH, 8'h12);
        chk_sum(16'h1234, "preset");
        feed(8'hab);
        exp = crc_ref(16'h1234, 8'hab, 1'b0);
        chk_sum(exp, "preset update");
        axi_wr(BCRC_OFS_CTRL, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk_sum(exp, "select change");
        feed(8'h5a);
        exp = crc_ref(exp, 8'h5a, 1'b1);
        chk_sum(exp, "new select");
        $display("test preset done");
    endtask : t_preset

    // A program word enters low byte first; the pair ends on the chained value.
    task automatic t_word();
        logic [15:0] exp;
        axi_wr(BCRC_OFS_CTRL, 8'h01);
        clr();
        feed(8'hcd);
        feed(8'hab);
        exp = crc_ref(crc_ref(16'h0000, 8'hcd, 1'b1), 8'hab, 1'b1);
        chk_sum(exp, "program word");
        $display("test program word done");
    endtask : t_word

    // A reset in mid-run must bring every register back to zero.
    task automatic t_rerun();
        feed(8'h3c);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        $display("test mid-run reset done");
    endtask : t_rerun

    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_ctrl();
        t_single();
        t_seq();
        t_preset();
        t_word();
        t_rerun();
        end_sim();
    end
endmodule : bcrc_unit_tb_top
